// file: pkg/ssp_pkg.sv
// constants and types for the serial port stop and pin select block
package ssp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_S1CTL = 8'h00;
  localparam logic [7:0] ADDR_S2C1 = 8'h04;
  localparam logic [7:0] ADDR_S2C2 = 8'h08;
  localparam logic [7:0] ADDR_DIR = 8'h0c;
  localparam logic [7:0] ADDR_PDAT = 8'h10;
  localparam logic [7:0] ADDR_PIN = 8'h14;
  localparam logic [7:0] ADDR_TXD = 8'h18;
  localparam logic [7:0] ADDR_RXD = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  // serial1_control fields
  localparam int S1_ENABLE = 7;
  localparam int S1_SYNC = 6;
  localparam int S1_RX_EN = 5;
  localparam int S1_TX_EN = 4;
  localparam int S1_RDY = 2;
  localparam int S1_CLK_SRC = 1;
  // serial2 control fields
  localparam int S2_PIN_EN = 3;
  localparam int S2_RDY = 4;
  localparam int S2_CLK_OUT = 6;
  localparam int S2_CMP = 6;
  // status fields
  localparam int ST_TBE = 0;
  localparam int ST_TSC = 1;
  localparam int ST_RBF = 2;
  localparam int ST_OVR = 3;
  localparam int ST_PAR = 4;
  localparam int ST_FRM = 5;
  localparam int ST_SUM = 6;
  // pin vector positions
  localparam int NPIN = 9;
  localparam int P_RXD = 0;
  localparam int P_TXD = 1;
  localparam int P_SERIAL1_CLOCK_PIN = 2;
  localparam int P_RDY1 = 3;
  localparam int P_SERIAL2_DATA_IN_PIN = 4;
  localparam int P_SERIAL2_DATA_OUT_PIN = 5;
  localparam int P_SERIAL2_CLOCK_PIN = 6;
  localparam int P_RDY2 = 7;
  localparam int P_CMP2 = 8;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [8:0] PORT_RST = 9'h000;
  // bits per frame, minus one, loaded into the shift counter
  localparam logic [3:0] SYNC_LAST = 4'h7;
  localparam logic [3:0] UART_LAST = 4'h9;
  localparam int SHIFT_DIV_DEF = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {TX_IDLE, TX_SHIFT} ssp_tx_type;
  typedef enum {RX_IDLE, RX_SHIFT} ssp_rx_type;
endpackage

// file: src/ssp_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module ssp_sync #(
  parameter int W = 9
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg; // first stage, read only by second stage
  logic [W-1:0] sync_reg; // second stage
  // both stages clear to low on reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// file: src/ssp_top.sv
// serial port stop/initialise and pin function select, axi4-lite registers
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Function
// - tx disable stops clocks, clears flags, frees pin
// - port disable frees all four serial1 pins
// - rx disable stops, clears errors, frees pin
// - port disable also resets receive state and flags
// - uart directions stop independently
// - port1 sync or uart, port2 sync
// - enable, mode and data pin routing bits
// - sync clock pin and ready pin select
// - uart clock pin select, ready is port
// - port2 pin enable, clock, ready, compare
module ssp_top import ssp_pkg::*; #(
  parameter int SHIFT_DIV = SHIFT_DIV_DEF
) (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [NPIN-1:0] I_PIN,
  output logic [NPIN-1:0] O_PIN,
  output logic [NPIN-1:0] O_PIN_OE
);
  logic [NPIN-1:0] pin_s; // synchronised pin levels
  ssp_sync #(.W(NPIN)) u_sync (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_async(I_PIN),
    .o_sync(pin_s)
  );

  // bus state
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [1:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // software registers
  logic [7:0] ctl1_reg, ctl1_next, c21_reg, c21_next, c22_reg, c22_next;
  logic [8:0] dir_reg, dir_next, pdat_reg, pdat_next;
  // engine state
  logic [15:0] div_reg, div_next;
  logic iclk_reg, iclk_next, sclk_prev_reg;
  ssp_tx_type tx_st_reg, tx_st_next;
  ssp_rx_type rx_st_reg, rx_st_next;
  logic [7:0] tx_buf_reg, tx_buf_next, rx_buf_reg, rx_buf_next;
  logic tx_full_reg, tx_full_next, tsc_reg, tsc_next;
  logic [8:0] tx_sh_reg, tx_sh_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic txo_reg, txo_next, rbf_reg, rbf_next, ovr_reg, ovr_next, frm_reg, frm_next;
  logic par_reg; // no parity engine here, held clear
  // decoded controls and strobes
  logic port_enable_bit, syncm, ext_clk, tx_en, rx_en, wr_do, rd_do, wr_ok, rd_ok;
  logic int_rise, int_fall, ext_rise, ext_fall, tx_tick, rx_tick;
  logic [7:0] stat;

  assign port_enable_bit = ctl1_reg[S1_ENABLE];
  assign syncm = ctl1_reg[S1_SYNC];
  assign ext_clk = ctl1_reg[S1_CLK_SRC];
  assign tx_en = port_enable_bit & ctl1_reg[S1_TX_EN];
  assign rx_en = port_enable_bit & ctl1_reg[S1_RX_EN];
  assign stat = {1'b0, ovr_reg | par_reg | frm_reg, frm_reg, par_reg, ovr_reg,
                 rbf_reg, tsc_reg, tx_en & ~tx_full_reg};

  // handshake outputs come from registers only, no path from bus inputs
  assign O_AWREADY = ~aw_got_reg & ~bvalid_reg;
  assign O_WREADY = ~w_got_reg & ~bvalid_reg;
  assign O_ARREADY = ~rvalid_reg;
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RRESP = rresp_reg;
  assign O_RDATA = rdata_reg;
  assign wr_do = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign rd_do = I_ARVALID & ~rvalid_reg;
  assign wr_ok = aw_addr_reg <= ADDR_STAT && aw_addr_reg[1:0] == 2'h0;
  assign rd_ok = I_ARADDR <= ADDR_STAT && I_ARADDR[1:0] == 2'h0;

  // bus channel next state; unmapped addresses answer slverr
  always_comb begin
    aw_got_next = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next = w_got_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (I_AWVALID && O_AWREADY) begin
      aw_got_next = 1'b1;
      aw_addr_next = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_got_next = 1'b1;
      w_data_next = I_WDATA;
      w_strb_next = I_WSTRB[1:0];
    end
    if (wr_do) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && I_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (rd_do) begin
      rvalid_next = 1'b1;
      rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
      case (I_ARADDR)
        ADDR_S1CTL: rdata_next = {24'h000000, ctl1_reg};
        ADDR_S2C1: rdata_next = {24'h000000, c21_reg};
        ADDR_S2C2: rdata_next = {24'h000000, c22_reg};
        ADDR_DIR: rdata_next = {23'h000000, dir_reg};
        ADDR_PDAT: rdata_next = {23'h000000, pdat_reg};
        ADDR_PIN: rdata_next = {23'h000000, pin_s};
        ADDR_RXD: rdata_next = {24'h000000, rx_buf_reg};
        ADDR_STAT: rdata_next = {24'h000000, stat};
        default: rdata_next = 32'h00000000;
      endcase
    end else if (rvalid_reg && I_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  // software register writes, byte lane 0 and bit 8 from lane 1
  always_comb begin
    ctl1_next = ctl1_reg;
    c21_next = c21_reg;
    c22_next = c22_reg;
    dir_next = dir_reg;
    pdat_next = pdat_reg;
    if (wr_do && w_strb_reg[0]) begin
      case (aw_addr_reg)
        ADDR_S1CTL: ctl1_next = w_data_reg[7:0];
        ADDR_S2C1: c21_next = w_data_reg[7:0];
        ADDR_S2C2: c22_next = w_data_reg[7:0];
        ADDR_DIR: dir_next[7:0] = w_data_reg[7:0];
        ADDR_PDAT: pdat_next[7:0] = w_data_reg[7:0];
        default: ctl1_next = ctl1_reg;
      endcase
    end
    if (wr_do && w_strb_reg[1] && aw_addr_reg == ADDR_DIR) begin
      dir_next[8] = w_data_reg[8];
    end
    if (wr_do && w_strb_reg[1] && aw_addr_reg == ADDR_PDAT) begin
      pdat_next[8] = w_data_reg[8];
    end
  end

  // shift clock sources: free divider or external clock pin edges
  assign int_rise = div_reg == 16'(SHIFT_DIV - 1) && !iclk_reg;
  assign int_fall = div_reg == 16'(SHIFT_DIV - 1) && iclk_reg;
  assign ext_rise = pin_s[P_SERIAL1_CLOCK_PIN] & ~sclk_prev_reg;
  assign ext_fall = ~pin_s[P_SERIAL1_CLOCK_PIN] & sclk_prev_reg;
  // sync: shift out on fall, sample on rise; internal clock only while sending
  assign tx_tick = syncm ? (ext_clk ? ext_fall : int_fall) : (ext_clk ? ext_rise : int_rise);
  assign rx_tick = ext_clk ? ext_rise : (int_rise & (~syncm | tx_st_reg == TX_SHIFT));

  // transmit and receive engines
  always_comb begin
    div_next = (div_reg == 16'(SHIFT_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
    iclk_next = (div_reg == 16'(SHIFT_DIV - 1)) ? ~iclk_reg : iclk_reg;
    tx_st_next = tx_st_reg;
    tx_buf_next = tx_buf_reg;
    tx_full_next = tx_full_reg;
    tsc_next = tsc_reg;
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    txo_next = txo_reg;
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_buf_next = rx_buf_reg;
    rbf_next = rbf_reg;
    ovr_next = ovr_reg;
    frm_next = frm_reg;
    if (!tx_en && !rx_en) begin
      div_next = 16'h0000;
      iclk_next = 1'b1; // clock idles high
    end
    if (wr_do && aw_addr_reg == ADDR_TXD && w_strb_reg[0]) begin
      tx_buf_next = w_data_reg[7:0];
      tx_full_next = 1'b1;
    end
    if (tx_tick) begin
      case (tx_st_reg)
        TX_IDLE: begin
          if (tx_full_reg) begin
            // uart frame: start bit first, stop bit last
            tx_st_next = TX_SHIFT;
            tx_full_next = 1'b0;
            tsc_next = 1'b0;
            txo_next = syncm ? tx_buf_reg[0] : 1'b0;
            tx_sh_next = syncm ? {2'h3, tx_buf_reg[7:1]} : {1'b1, tx_buf_reg};
            tx_cnt_next = syncm ? SYNC_LAST : UART_LAST;
          end
        end
        TX_SHIFT: begin
          if (tx_cnt_reg == 4'h0) begin
            tx_st_next = TX_IDLE;
            tsc_next = 1'b1;
            txo_next = 1'b1;
          end else begin
            txo_next = tx_sh_reg[0];
            tx_sh_next = {1'b1, tx_sh_reg[8:1]};
            tx_cnt_next = tx_cnt_reg - 4'h1;
          end
        end
        default: tx_st_next = TX_IDLE;
      endcase
    end
    // external sync clock: the frame ends at the rising edge that takes the last bit,
    // since a far end that parks its clock never gives a ninth falling edge
    if (syncm && ext_clk && ext_rise && tx_st_reg == TX_SHIFT && tx_cnt_reg == 4'h0) begin
      tx_st_next = TX_IDLE;
      tsc_next = 1'b1;
      txo_next = 1'b1;
    end
    // tx disable: stop shifting, reset clock control, clear flags
    if (!tx_en) begin
      tx_st_next = TX_IDLE;
      tx_full_next = 1'b0;
      tsc_next = 1'b0;
      txo_next = 1'b1;
      tx_cnt_next = 4'h0;
    end
    // read of rx data clears the flag; a completion below in the same cycle wins
    if (rd_do && I_ARADDR == ADDR_RXD) begin
      rbf_next = 1'b0;
    end
    if (rx_tick) begin
      case (rx_st_reg)
        RX_IDLE: begin
          // sync takes the first bit now; uart waits for a low start bit
          if (syncm) begin
            rx_st_next = RX_SHIFT;
            rx_sh_next = {pin_s[P_RXD], rx_sh_reg[7:1]};
            rx_cnt_next = 4'h1;
          end else if (!pin_s[P_RXD]) begin
            rx_st_next = RX_SHIFT;
            rx_cnt_next = 4'h0;
          end
        end
        RX_SHIFT: begin
          if (rx_cnt_reg < 4'h8) begin
            rx_sh_next = {pin_s[P_RXD], rx_sh_reg[7:1]};
            rx_cnt_next = rx_cnt_reg + 4'h1;
          end
          if ((syncm && rx_cnt_reg == 4'h7) || (!syncm && rx_cnt_reg == 4'h8)) begin
            rx_st_next = RX_IDLE;
            rx_buf_next = syncm ? {pin_s[P_RXD], rx_sh_reg[7:1]} : rx_sh_reg;
            ovr_next = ovr_reg | rbf_next; // a byte read this cycle is no overrun
            rbf_next = 1'b1;
            frm_next = frm_reg | (~syncm & ~pin_s[P_RXD]);
          end
        end
        default: rx_st_next = RX_IDLE;
      endcase
    end
    // rx or port disable: stop, reset clock control, clear flags
    if (!rx_en) begin
      rx_st_next = RX_IDLE;
      rx_cnt_next = 4'h0;
      rbf_next = 1'b0;
      ovr_next = 1'b0;
      frm_next = 1'b0;
    end
  end

  // register everything; synchronous reset
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 2'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
      ctl1_reg <= CTL_RST;
      c21_reg <= CTL_RST;
      c22_reg <= CTL_RST;
      dir_reg <= PORT_RST;
      pdat_reg <= PORT_RST;
      div_reg <= 16'h0000;
      iclk_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
      tx_st_reg <= TX_IDLE;
      rx_st_reg <= RX_IDLE;
      tx_buf_reg <= 8'h00;
      rx_buf_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      tsc_reg <= 1'b0;
      tx_sh_reg <= 9'h1ff;
      rx_sh_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      txo_reg <= 1'b1;
      rbf_reg <= 1'b0;
      ovr_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg <= w_got_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctl1_reg <= ctl1_next;
      c21_reg <= c21_next;
      c22_reg <= c22_next;
      dir_reg <= dir_next;
      pdat_reg <= pdat_next;
      div_reg <= div_next;
      iclk_reg <= iclk_next;
      sclk_prev_reg <= pin_s[P_SERIAL1_CLOCK_PIN];
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      tx_buf_reg <= tx_buf_next;
      rx_buf_reg <= rx_buf_next;
      tx_full_reg <= tx_full_next;
      tsc_reg <= tsc_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      txo_reg <= txo_next;
      rbf_reg <= rbf_next;
      ovr_reg <= ovr_next;
      frm_reg <= frm_next;
      par_reg <= 1'b0;
    end
  end

  // pin function select; a deselected pin is a port
  always_comb begin
    O_PIN = pdat_reg;
    O_PIN_OE = dir_reg;
    if (port_enable_bit) begin
      if (ctl1_reg[S1_RX_EN]) begin
        O_PIN_OE[P_RXD] = 1'b0;
      end
      if (ctl1_reg[S1_TX_EN]) begin
        O_PIN[P_TXD] = txo_reg;
        O_PIN_OE[P_TXD] = 1'b1;
      end
      if (ext_clk) begin
        O_PIN_OE[P_SERIAL1_CLOCK_PIN] = 1'b0;
      end else if (syncm && ctl1_reg[S1_TX_EN]) begin
        O_PIN[P_SERIAL1_CLOCK_PIN] = tx_st_reg == TX_SHIFT ? iclk_reg : 1'b1;
        O_PIN_OE[P_SERIAL1_CLOCK_PIN] = 1'b1;
      end
      if (syncm && ctl1_reg[S1_RDY]) begin
        O_PIN[P_RDY1] = ~(rx_en & ~rbf_reg); // low means ready
        O_PIN_OE[P_RDY1] = 1'b1;
      end
    end
    // port2 has no uart mode; pins only, idle levels driven
    if (c21_reg[S2_PIN_EN]) begin
      O_PIN_OE[P_SERIAL2_DATA_IN_PIN] = 1'b0;
      O_PIN[P_SERIAL2_DATA_OUT_PIN] = 1'b1;
      O_PIN_OE[P_SERIAL2_DATA_OUT_PIN] = 1'b1;
      O_PIN[P_SERIAL2_CLOCK_PIN] = 1'b1;
      O_PIN_OE[P_SERIAL2_CLOCK_PIN] = c21_reg[S2_CLK_OUT];
      if (c21_reg[S2_RDY]) begin
        O_PIN[P_RDY2] = 1'b1;
        O_PIN_OE[P_RDY2] = 1'b1;
      end
      if (c22_reg[S2_CMP]) begin
        O_PIN[P_CMP2] = 1'b0;
        O_PIN_OE[P_CMP2] = 1'b1;
      end
    end
  end

  // checks on the stop behaviour and pin routing
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  a_tx_stop_init: assert property ($fell(tx_en) |=> tx_st_reg == TX_IDLE && !tsc_reg
    && !stat[ST_TBE] && O_PIN_OE[P_TXD] == dir_reg[P_TXD])
    else $error("tx not stopped after disable");
  a_port_release: assert property (!port_enable_bit |-> O_PIN_OE[3:0] == dir_reg[3:0]
    && O_PIN[3:0] == pdat_reg[3:0])
    else $error("serial1 pins not released");
  a_rx_stop_init: assert property ($fell(rx_en) |=> !rbf_reg && !ovr_reg && !frm_reg
    && rx_st_reg == RX_IDLE)
    else $error("rx not stopped after disable");
  a_port_enable_bit_rx_stop: assert property ($fell(port_enable_bit) && ctl1_reg[S1_RX_EN] |=> !rbf_reg
    && !stat[ST_SUM])
    else $error("port disable left rx flags");
  a_uart_indep: assert property (!syncm && tx_en && tx_st_reg == TX_SHIFT && !tx_tick
    && $fell(rx_en) |=> tx_st_reg == TX_SHIFT)
    else $error("rx disable disturbed tx");
  a_frame_len: assert property ($rose(tx_st_reg == TX_SHIFT) |->
    tx_cnt_reg == (syncm ? SYNC_LAST : UART_LAST))
    else $error("wrong frame length");
  a_sync_clk_out: assert property (port_enable_bit && syncm && !ext_clk && ctl1_reg[S1_TX_EN]
    |-> O_PIN_OE[P_SERIAL1_CLOCK_PIN])
    else $error("internal clock not driven");
  a_uart_rdy_port: assert property (port_enable_bit && !syncm |-> O_PIN_OE[P_RDY1] == dir_reg[P_RDY1]
    && (ext_clk || O_PIN_OE[P_SERIAL1_CLOCK_PIN] == dir_reg[P_SERIAL1_CLOCK_PIN]))
    else $error("uart clock or ready pin wrong");
  a_s2_pin_sel: assert property ((!c21_reg[S2_PIN_EN] |-> O_PIN_OE[8:4] == dir_reg[8:4])
    and (c21_reg[S2_PIN_EN] |-> O_PIN_OE[P_SERIAL2_CLOCK_PIN] == c21_reg[S2_CLK_OUT]))
    else $error("port2 pin select wrong");
  a_rx_pin_route: assert property (port_enable_bit && !ctl1_reg[S1_RX_EN] |->
    O_PIN_OE[P_RXD] == dir_reg[P_RXD])
    else $error("rx pin not a port");
  c_tx_done: cover property ($rose(tsc_reg));
  c_rx_full: cover property ($rose(rbf_reg));
  c_overrun: cover property ($rose(ovr_reg));
  c_frame_err: cover property ($rose(frm_reg));
endmodule
`default_nettype wire

// file: sim/ssp_peer.sv
// far-end peer model: link clock, receive data, transmit data capture
`timescale 1ns/10ps
`default_nettype none
module ssp_peer #(
  parameter int HALF = 200
) (
  input wire logic i_txd,
  output logic o_sclk,
  output logic o_rxd
);
  // clock stands high outside frames, data released to its pull-up
  initial begin
    o_sclk = 1'b1;
    o_rxd = 1'b1;
  end
  // data moves after the falling edge, both ends sample on the rising edge
  task automatic frame(input logic [9:0] tx, input int n, output logic [9:0] rx);
    rx = 10'h000;
    for (int i = 0; i < n; i++) begin
      // non-blocking, so a change on a system clock edge never races the sampling flops
      o_sclk <= 1'b0;
      o_rxd <= tx[i];
      #HALF;
      o_sclk <= 1'b1;
      rx[i] = i_txd;
      #HALF;
    end
    o_rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench: registers, pin select table, stop and initialise
`timescale 1ns/10ps
`default_nettype none
module testbench import ssp_pkg::*;;
  // one table row: register values and the pins they should give
  typedef struct {
    logic [7:0] c1;
    logic [7:0] c21;
    logic [7:0] c22;
    logic [8:0] dir;
    logic [8:0] dat;
    logic [8:0] oe;
    logic [8:0] pm;
    logic [8:0] pv;
  } ssp_row_type;
  ssp_row_type rows [12];
  logic I_SYS_CLK = 1'b0;
  logic I_SRST = 1'b1;
  logic [7:0] I_AWADDR = 8'h00;
  logic I_AWVALID = 1'b0;
  logic [31:0] I_WDATA = 32'h0;
  logic I_WVALID = 1'b0;
  logic [7:0] I_ARADDR = 8'h00;
  logic I_ARVALID = 1'b0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA, rd_d;
  logic [NPIN-1:0] O_PIN, O_PIN_OE, pin_w;
  logic p_sclk, p_rxd;
  logic [9:0] got;
  logic [1:0] rd_r;
  int miscompares = 0;
  int n_checks = 0;
  // 20 MHz system clock
  always #25 I_SYS_CLK = ~I_SYS_CLK;
  // wire level: device where it drives, else peer or pull-up
  assign pin_w = (O_PIN & O_PIN_OE) | ({6'h3f, p_sclk, 1'b1, p_rxd} & ~O_PIN_OE);
  // short divider keeps the run brief; ready channels held open
  ssp_top #(.SHIFT_DIV(2)) dut (.I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST),
    .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WDATA(I_WDATA), .I_WSTRB(4'hf), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(1'b1), .I_ARADDR(I_ARADDR),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(1'b1), .I_PIN(pin_w),
    .O_PIN(O_PIN), .O_PIN_OE(O_PIN_OE));
  ssp_peer peer (.i_txd(pin_w[P_TXD]), .o_sclk(p_sclk), .o_rxd(p_rxd));
  // compare and count
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    n_checks++;
    if (got_v !== exp_v) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  // write: readies sampled at the falling edge, valids dropped after the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(negedge I_SYS_CLK);
      aw = I_AWVALID & O_AWREADY;
      w = I_WVALID & O_WREADY;
      b = O_BVALID;
      r = O_BRESP;
      @(posedge I_SYS_CLK);
      if (aw) I_AWVALID <= 1'b0;
      if (w) I_WVALID <= 1'b0;
    end while (!b);
  endtask
  // read: address held until taken, data taken with rvalid
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    do begin
      @(negedge I_SYS_CLK);
      ar = I_ARVALID & O_ARREADY;
      v = O_RVALID;
      d = O_RDATA;
      r = O_RRESP;
      @(posedge I_SYS_CLK);
      if (ar) I_ARVALID <= 1'b0;
    end while (!v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d & m, e);
  endtask
  // pin enables and masked pin values, looked at mid-cycle
  task automatic pchk(input logic [8:0] oe, input logic [8:0] m, input logic [8:0] pv);
    @(negedge I_SYS_CLK);
    chk({23'h0, O_PIN_OE}, {23'h0, oe});
    chk({23'h0, O_PIN & m}, {23'h0, pv});
    @(posedge I_SYS_CLK);
  endtask
  // one system clock edge of slack after each frame
  task automatic settle();
    @(posedge I_SYS_CLK);
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: whole run needs well under 100 us
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  // main sequence
  initial begin
    rows = '{'{8'h00, 8'h00, 8'h00, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000},
      '{8'hd0, 8'h00, 8'h00, 9'h000, 9'h000, 9'h006, 9'h000, 9'h000},
      '{8'hd2, 8'h00, 8'h00, 9'h000, 9'h000, 9'h002, 9'h000, 9'h000},
      '{8'hc4, 8'h00, 8'h00, 9'h000, 9'h000, 9'h008, 9'h000, 9'h000},
      '{8'h54, 8'h00, 8'h00, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000},
      '{8'h96, 8'h00, 8'h00, 9'h000, 9'h000, 9'h002, 9'h000, 9'h000},
      '{8'h90, 8'h00, 8'h00, 9'h000, 9'h000, 9'h002, 9'h000, 9'h000},
      '{8'h00, 8'h58, 8'h40, 9'h000, 9'h000, 9'h1e0, 9'h1e0, 9'h0e0},
      '{8'h00, 8'h50, 8'h00, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000},
      '{8'h00, 8'h08, 8'h00, 9'h000, 9'h000, 9'h020, 9'h020, 9'h020},
      '{8'h00, 8'h00, 8'h00, 9'h1ff, 9'h155, 9'h1ff, 9'h1ff, 9'h155},
      '{8'hf0, 8'h00, 8'h00, 9'h1ff, 9'h155, 9'h1fe, 9'h1f0, 9'h150}};
    repeat (5) @(posedge I_SYS_CLK);
    I_SRST <= 1'b0;
    rdc(ADDR_S1CTL, 32'hff, 32'h0);
    rdc(ADDR_S2C1, 32'hff, 32'h0);
    rdc(ADDR_S2C2, 32'hff, 32'h0);
    foreach (rows[i]) begin
      wr(ADDR_DIR, {23'h0, rows[i].dir});
      wr(ADDR_PDAT, {23'h0, rows[i].dat});
      wr(ADDR_S2C1, {24'h0, rows[i].c21});
      wr(ADDR_S2C2, {24'h0, rows[i].c22});
      wr(ADDR_S1CTL, {24'h0, rows[i].c1});
      rdc(ADDR_S1CTL, 32'hff, {24'h0, rows[i].c1});
      pchk(rows[i].oe, rows[i].pm, rows[i].pv);
    end
    // bad address and misaligned read
    axw(8'h24, 32'h1, rd_r);
    chk({30'h0, rd_r}, {30'h0, RESP_SLVERR});
    axr(8'h02, rd_d, rd_r);
    chk({rd_d[29:0], rd_r}, {30'h0, RESP_SLVERR});
    // synchronous frames on an external clock
    wr(ADDR_DIR, 32'h0);
    wr(ADDR_S1CTL, 32'hf2);
    wr(ADDR_TXD, 32'h3c);
    peer.frame(10'h0a5, 8, got);
    chk({22'h0, got}, 32'h3c);
    settle();
    rdc(ADDR_STAT, 32'h7c, 32'h04);
    rdc(ADDR_RXD, 32'hff, 32'ha5);
    peer.frame(10'h05a, 8, got);
    settle();
    rdc(ADDR_STAT, 32'h7c, 32'h04);
    wr(ADDR_S1CTL, 32'hc2);
    rdc(ADDR_STAT, 32'h7f, 32'h00);
    pchk(9'h000, 9'h000, 9'h000);
    // ready pin follows buffer state, then whole port off
    wr(ADDR_S1CTL, 32'hf6);
    pchk(9'h00a, 9'h008, 9'h000);
    peer.frame(10'h033, 8, got);
    settle();
    pchk(9'h00a, 9'h008, 9'h008);
    wr(ADDR_S1CTL, 32'h76);
    rdc(ADDR_STAT, 32'h7f, 32'h00);
    pchk(9'h000, 9'h000, 9'h000);
    // uart: good frame, then a frame with a zero stop bit
    wr(ADDR_S1CTL, 32'hb2);
    peer.frame(10'h2d2, 10, got);
    settle();
    rdc(ADDR_STAT, 32'h7c, 32'h04);
    rdc(ADDR_RXD, 32'hff, 32'h69);
    peer.frame(10'h0d2, 10, got);
    settle();
    rdc(ADDR_STAT, 32'h7c, 32'h64);
    wr(ADDR_S1CTL, 32'h92);
    rdc(ADDR_STAT, 32'h7c, 32'h00);
    pchk(9'h002, 9'h000, 9'h000);
    // sync transmit on the internal clock: empty and complete flags, then tx off
    wr(ADDR_S1CTL, 32'hd0);
    wr(ADDR_TXD, 32'h3c);
    repeat (60) @(posedge I_SYS_CLK);
    rdc(ADDR_STAT, 32'h03, 32'h03);
    wr(ADDR_S1CTL, 32'hc0);
    rdc(ADDR_STAT, 32'h03, 32'h00);
    // reset again in mid-run: controls, flags and pins back to reset state
    I_SRST <= 1'b1;
    repeat (2) @(posedge I_SYS_CLK);
    I_SRST <= 1'b0;
    rdc(ADDR_S1CTL, 32'hff, 32'h0);
    rdc(ADDR_STAT, 32'h7f, 32'h0);
    pchk(9'h000, 9'h1ff, 9'h000);
    complete_run();
  end
endmodule
`default_nettype wire
